//--- regfile_defs.svh
`ifndef REGFILE_DEFS_SVH
`define REGFILE_DEFS_SVH

// register count and width
`define RF_NUM_REGS      32
`define RF_ADDR_W        5
`define RF_DATA_W        8
`define RF_RESET_VAL     8'h00

// pointer register pairs, low byte index (high byte is index plus one)
`define RF_PTR1_LO       5'h1a
`define RF_PTR2_LO       5'h1c
`define RF_PTR3_LO       5'h1e

// data space window occupied by the working registers
`define RF_DS_LIMIT      16'h0020

// extended-load page register reset value
`define RF_PAGE_RESET    1'h0

`endif

//--- regfile_pkg.sv
package regfile_pkg;

    // pointer selection for indirect and program-memory addressing
    typedef enum logic [2:0] {
        PTR_FIRST  = 3'b001,
        PTR_SECOND = 3'b010,
        PTR_THIRD  = 3'b100
    } ptr_sel_e;

endpackage : regfile_pkg

//--- regfile_mem.sv
`timescale 1ns/100ps
`default_nettype none
`include "regfile_defs.svh"

module regfile_mem (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // write port
    input  wire logic       i_we,
    input  wire logic [4:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    // second write port, used for the pointer high byte
    input  wire logic       i_we2,
    input  wire logic [4:0] i_waddr2,
    input  wire logic [7:0] i_wdata2,
    // whole array, read combinationally by the owner
    output logic [255:0]    o_flat
);

    logic [7:0] regs_r   [0:31];
    logic [7:0] regs_nxt [0:31];

    // next values: port two wins on a clash, it carries pointer updates
    always_comb begin
        for (int i = 0; i < `RF_NUM_REGS; i++) begin
            regs_nxt[i] = regs_r[i];
            if (i_we && (i_waddr == 5'(i))) begin
                regs_nxt[i] = i_wdata;
            end
            if (i_we2 && (i_waddr2 == 5'(i))) begin
                regs_nxt[i] = i_wdata2;
            end
        end
    end

    // register array
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < `RF_NUM_REGS; i++) begin
            if (i_rst) begin
                regs_r[i] <= `RF_RESET_VAL;
            end else begin
                regs_r[i] <= regs_nxt[i];
            end
        end
    end

    // flatten for the owner
    always_comb begin
        for (int i = 0; i < `RF_NUM_REGS; i++) begin
            o_flat[i*8 +: 8] = regs_r[i];
        end
    end

endmodule : regfile_mem

`default_nettype wire

//--- cpu_working_register_file.sv
`timescale 1ns/100ps
`default_nettype none
`include "regfile_defs.svh"

// How it works
// - thirty-two byte registers are held, each readable and writable in one clock.
// - two operands are read and one result is written back in the same cycle.
// - three register pairs act as the first, second and third 16-bit data pointers.
// - the third pointer also supplies the program-memory constant lookup address.
// - with the large-memory option the extended load adds a page bit above that address.
// - data space addresses below hex 20 read and write the working registers.
module cpu_working_register_file
    import regfile_pkg::*;
#(
    parameter bit LARGE_MEM = 1'b1
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // alu operand selects
    input  wire logic [4:0] i_rd_addr,
    input  wire logic [4:0] i_rr_addr,
    // alu result write back
    input  wire logic       i_res_we,
    input  wire logic [4:0] i_res_addr,
    input  wire logic [7:0] i_res_data,
    // pointer select and 16-bit pointer write back
    input  wire logic [2:0] i_ptr_sel,
    input  wire logic       i_ptr_we,
    input  wire logic [15:0] i_ptr_data,
    // data space access
    input  wire logic       i_ds_re,
    input  wire logic       i_ds_we,
    input  wire logic [15:0] i_ds_addr,
    input  wire logic [7:0] i_ds_wdata,
    // program-memory load requests
    input  wire logic       i_pm_load,
    input  wire logic       i_ext_load,
    input  wire logic       i_page_we,
    input  wire logic       i_page_data,
    // operands for the alu
    output logic [7:0]      o_rd_data,
    output logic [7:0]      o_rr_data,
    // selected pointer and constant lookup address
    output logic [15:0]     o_ptr,
    output logic [16:0]     o_pm_addr,
    output logic            o_pm_valid,
    output logic            o_ext_illegal,
    // data space answer
    output logic [7:0]      o_ds_rdata,
    output logic            o_ds_hit
);

    // array view and the two write ports
    logic [255:0] flat;
    logic         we;
    logic [4:0]   waddr;
    logic [7:0]   wdata;
    logic         we2;
    logic [4:0]   waddr2;
    logic [7:0]   wdata2;

    // window decode and pointer base register
    logic         ds_in;
    logic [4:0]   plo;

    // page bit and next values of the output registers
    logic         page_r;
    logic         page_nxt;
    logic [7:0]   rd_nxt;
    logic [7:0]   rr_nxt;
    logic [15:0]  ptr_nxt;
    logic [16:0]  pm_nxt;
    logic         pmv_nxt;
    logic         ill_nxt;
    logic [7:0]   dsr_nxt;
    logic         dsh_nxt;

    // selected pointer and third pointer as read from the array
    logic [15:0]  ptr_cur;
    logic [15:0]  ptr3;

    // read one byte out of the flattened array
    function automatic logic [7:0] rd_byte(input logic [255:0] f, input logic [4:0] a);
        rd_byte = f[{a, 3'b000} +: 8];
    endfunction : rd_byte

    // low byte from lower register, high byte from the next one
    function automatic logic [15:0] pair(input logic [255:0] f, input logic [4:0] lo);
        pair = {rd_byte(f, lo + 5'd1), rd_byte(f, lo)};
    endfunction : pair

    // register index of a data space address inside the window
    function automatic logic [4:0] win_idx(input logic [15:0] a);
        win_idx = a[4:0];
    endfunction : win_idx

    // base register of the selected pointer
    always_comb begin
        unique case (i_ptr_sel)
            PTR_FIRST:  plo = `RF_PTR1_LO;
            PTR_SECOND: plo = `RF_PTR2_LO;
            PTR_THIRD:  plo = `RF_PTR3_LO;
            default:    plo = `RF_PTR3_LO;
        endcase
    end

    // window decode and pointer views; all sixteen address bits are compared,
    // so no address above the window aliases onto a register
    assign ds_in   = (i_ds_addr < `RF_DS_LIMIT);
    assign ptr_cur = pair(flat, plo);
    assign ptr3    = pair(flat, `RF_PTR3_LO);

    // write port selection: alu result first, data space store otherwise
    always_comb begin
        we     = 1'b0;
        waddr  = i_res_addr;
        wdata  = i_res_data;
        // a data space store in the same cycle as a result is dropped
        if (i_res_we) begin
            we = 1'b1;
        end else if (i_ds_we && ds_in) begin
            we    = 1'b1;
            waddr = win_idx(i_ds_addr);
            wdata = i_ds_wdata;
        end
        // the pointer high byte always takes port two
        we2    = i_ptr_we;
        waddr2 = plo + 5'd1;
        wdata2 = i_ptr_data[15:8];
    end

    // pointer low byte rides on the main port when no result and no data space store is written
    // a port writes one byte per cycle, so on a clash the low byte gives way
    logic        we_m;
    logic [4:0]  waddr_m;
    logic [7:0]  wdata_m;
    logic        we_l;
    always_comb begin
        we_m    = we;
        waddr_m = waddr;
        wdata_m = wdata;
        we_l    = i_ptr_we && !we;
        if (we_l) begin
            we_m    = 1'b1;
            waddr_m = plo;
            wdata_m = i_ptr_data[7:0];
        end
    end

    // the array itself; port two carries only the pointer high byte
    regfile_mem u_mem (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_we     (we_m),
        .i_waddr  (waddr_m),
        .i_wdata  (wdata_m),
        .i_we2    (we2),
        .i_waddr2 (waddr2),
        .i_wdata2 (wdata2),
        .o_flat   (flat)
    );

    // next outputs: operands, pointer, lookup address, data space read
    always_comb begin
        // operands and selected pointer
        rd_nxt   = rd_byte(flat, i_rd_addr);
        rr_nxt   = rd_byte(flat, i_rr_addr);
        ptr_nxt  = ptr_cur;
        // page bit, held only by the larger variant
        page_nxt = page_r;
        if (i_page_we && LARGE_MEM) begin
            page_nxt = i_page_data;
        end
        // constant lookup address, third pair below the page bit
        pm_nxt   = {1'b0, ptr3};
        pmv_nxt  = 1'b0;
        ill_nxt  = 1'b0;
        if (i_ext_load) begin
            if (LARGE_MEM) begin
                pm_nxt  = {page_r, ptr3};
                pmv_nxt = 1'b1;
            end else begin
                // the smaller variant flags the request instead of fetching
                ill_nxt = 1'b1;
            end
        end else if (i_pm_load) begin
            pmv_nxt = 1'b1;
        end
        // data space read, zero outside the window
        dsh_nxt  = i_ds_re && ds_in;
        dsr_nxt  = dsh_nxt ? rd_byte(flat, win_idx(i_ds_addr)) : 8'h00;
    end

    // output and page registers; reads see the array before this edge's write,
    // so a value written at one edge reaches a read sampled at the next edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            // the page bit clears with the array, so a lookup after reset is low
            page_r        <= `RF_PAGE_RESET;
            o_rd_data     <= 8'h00;
            o_rr_data     <= 8'h00;
            o_ptr         <= 16'h0000;
            o_pm_addr     <= 17'h0_0000;
            o_pm_valid    <= 1'b0;
            o_ext_illegal <= 1'b0;
            o_ds_rdata    <= 8'h00;
            o_ds_hit      <= 1'b0;
        end else begin
            page_r        <= page_nxt;
            o_rd_data     <= rd_nxt;
            o_rr_data     <= rr_nxt;
            o_ptr         <= ptr_nxt;
            o_pm_addr     <= pm_nxt;
            o_pm_valid    <= pmv_nxt;
            o_ext_illegal <= ill_nxt;
            o_ds_rdata    <= dsr_nxt;
            o_ds_hit      <= dsh_nxt;
        end
    end

endmodule : cpu_working_register_file

`default_nettype wire

//--- regfile_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module regfile_monitor #(
    parameter bit LARGE_MEM = 1'b1
) (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // operand select and result write
    input wire logic [4:0]  i_rd_addr,
    input wire logic        i_res_we,
    input wire logic [4:0]  i_res_addr,
    input wire logic [7:0]  i_res_data,
    // pointer write
    input wire logic [2:0]  i_ptr_sel,
    input wire logic        i_ptr_we,
    input wire logic [15:0] i_ptr_data,
    // data space access
    input wire logic        i_ds_re,
    input wire logic        i_ds_we,
    input wire logic [15:0] i_ds_addr,
    // program-memory load requests
    input wire logic        i_pm_load,
    input wire logic        i_ext_load,
    // watched outputs
    input wire logic [7:0]  o_rd_data,
    input wire logic [15:0] o_ptr,
    input wire logic [16:0] o_pm_addr,
    input wire logic        o_pm_valid,
    input wire logic        o_ext_illegal,
    input wire logic [7:0]  o_ds_rdata,
    input wire logic        o_ds_hit
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // result write, then a read of the same register
    sequence res_then_rd;
        i_res_we && !i_ptr_we ##1 i_rd_addr == $past(i_res_addr);
    endsequence
    // lone pointer write, then the same pointer still selected
    sequence ptr_then_sel;
        i_ptr_we && !i_res_we && !i_ds_we ##1 i_ptr_sel == $past(i_ptr_sel) && !i_ptr_we;
    endsequence
    wr_rd_a: assert property (res_then_rd |=> o_rd_data == $past(i_res_data, 2))
        else $error("read after write wrong");
    ptr_pair_a: assert property (ptr_then_sel |=> o_ptr == $past(i_ptr_data, 2))
        else $error("pointer pair wrong");
    lookup_addr_a: assert property (i_pm_load && !i_ext_load && i_ptr_sel == 3'h4
        |=> o_pm_valid && o_pm_addr == {1'b0, o_ptr}) else $error("lookup address wrong");
    ext_gate_a: assert property (i_ext_load
        |=> o_pm_valid == LARGE_MEM && o_ext_illegal == !LARGE_MEM) else $error("ext load wrong");
    ds_hit_a: assert property (i_ds_re && i_ds_addr < 16'h0020 |=> o_ds_hit)
        else $error("window read missed");
    ds_miss_a: assert property (i_ds_re && i_ds_addr >= 16'h0020
        |=> !o_ds_hit && o_ds_rdata == 8'h00) else $error("read outside window hit");
    hit_cause_a: assert property (o_ds_hit |-> $past(i_ds_re) && $past(i_ds_addr) < 16'h0020)
        else $error("hit without read");
    valid_cause_a: assert property (o_pm_valid |-> $past(i_pm_load) || $past(i_ext_load))
        else $error("valid without load");
endmodule : regfile_monitor
`default_nettype wire

//--- alu_model.sv
`timescale 1ns/100ps
`default_nettype none
module alu_model (
    // operation and operands
    input wire logic       i_add,
    input wire logic [7:0] i_imm,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    // result
    output logic [7:0]     o_res
);
    // add the two operands or pass a constant
    assign o_res = i_add ? i_a + i_b : i_imm;
endmodule : alu_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import regfile_pkg::*;
    logic        i_clk, i_rst, i_res_we, i_ptr_we, i_ds_re, i_ds_we, i_pm_load, i_ext_load;
    logic        i_page_we, i_page_data, alu_add, o_pm_valid, o_ext_illegal, o_ds_hit;
    logic        small_valid, small_illegal;
    logic [4:0]  i_rd_addr, i_rr_addr, i_res_addr;
    logic [7:0]  i_res_data, i_ds_wdata, imm, o_rd_data, o_rr_data, o_ds_rdata;
    logic [2:0]  i_ptr_sel;
    logic [15:0] i_ptr_data, i_ds_addr, o_ptr, pd;
    logic [16:0] o_pm_addr;
    int          miscompares, n_tests;
    logic [12:0] rows [6] = '{13'h005a, 13'h0181, 13'h027e, 13'h0fc3, 13'h1a34, 13'h1fff};
    ptr_sel_e    sels [3] = '{PTR_FIRST, PTR_SECOND, PTR_THIRD};

    alu_model i_alu_model (.i_add(alu_add), .i_imm(imm), .i_a(o_rd_data), .i_b(o_rr_data),
        .o_res(i_res_data));
    cpu_working_register_file i_cpu_working_register_file (.*);
    cpu_working_register_file #(.LARGE_MEM(1'b0)) i_cpu_working_register_file_s (.*,
        .o_rd_data(), .o_rr_data(), .o_ptr(), .o_pm_addr(), .o_pm_valid(small_valid),
        .o_ext_illegal(small_illegal), .o_ds_rdata(), .o_ds_hit());

    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n = 1);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    task automatic finish_test;
        if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // stimulus and checks
    initial begin
        {i_res_we, i_ptr_we, i_ds_re, i_ds_we, i_pm_load, i_ext_load, i_page_we} = '0;
        {i_page_data, alu_add, i_rd_addr, i_rr_addr, i_res_addr, imm, i_ds_wdata} = '0;
        {i_ptr_sel, i_ptr_data, i_ds_addr} = '0;
        i_rst = 1'b1;
        cyc(6);
        chk("reset", 17'h0_0000, {o_pm_valid, o_ptr});
        i_rst = 1'b0;
        for (int k = 0; k < 6; k++) begin
            {i_res_addr, imm} = rows[k];
            i_res_we = 1'b1;
            cyc();
            i_res_we = 1'b0;
            i_rd_addr = rows[k][12:8];
            i_rr_addr = rows[k][12:8];
            i_ds_addr = {11'h000, rows[k][12:8]};
            i_ds_re = 1'b1;
            cyc();
            chk("operands", {1'b0, rows[k][7:0], rows[k][7:0]}, {1'b0, o_rd_data, o_rr_data});
            chk("ds read", {8'h00, 1'b1, rows[k][7:0]}, {8'h00, o_ds_hit, o_ds_rdata});
        end
        {i_rd_addr, i_rr_addr, i_res_addr} = {5'h01, 5'h02, 5'h03};
        cyc();
        {alu_add, i_res_we} = 2'h3;
        cyc();
        {alu_add, i_res_we, i_rd_addr} = {2'h0, 5'h03};
        cyc();
        chk("alu result", 17'h0_00ff, {9'h000, o_rd_data});
        for (int k = 0; k < 3; k++) begin
            pd = {8'ha5 + 8'(k), 8'h3c + 8'(k)};
            {i_ptr_sel, i_ptr_data, i_ptr_we} = {sels[k], pd, 1'b1};
            cyc();
            i_ptr_we = 1'b0;
            i_rd_addr = 5'h1a + 5'(2 * k);
            i_rr_addr = 5'h1b + 5'(2 * k);
            cyc();
            chk("pointer", {1'b0, pd}, {1'b0, o_ptr});
            chk("pair", {1'b0, pd}, {1'b0, o_rr_data, o_rd_data});
        end
        {i_page_we, i_page_data} = 2'h3;
        cyc();
        {i_page_we, i_ext_load} = 2'h1;
        cyc();
        i_ext_load = 1'b0;
        chk("ext addr", {1'b1, pd}, o_pm_addr);
        chk("ext flags", 17'h0_0009, {small_illegal, small_valid, o_ext_illegal, o_pm_valid});
        i_pm_load = 1'b1;
        cyc();
        i_pm_load = 1'b0;
        chk("lookup", {1'b0, pd}, o_pm_addr);
        {i_ds_we, i_ds_addr, i_ds_wdata} = {1'b1, 16'h001f, 8'h6d};
        cyc();
        {i_ds_addr, i_ds_wdata} = {16'h0020, 8'hee};
        cyc();
        {i_ds_we, i_rd_addr, i_rr_addr} = {1'b0, 5'h1f, 5'h00};
        cyc();
        chk("out of window", 17'h0_0000, {8'h00, o_ds_hit, o_ds_rdata});
        chk("ds write", 17'h0_6d5a, {1'b0, o_rd_data, o_rr_data});
        // reset in mid-run clears the array and the page bit
        i_rst = 1'b1;
        cyc();
        {i_rst, i_ext_load} = 2'h1;
        cyc();
        i_ext_load = 1'b0;
        chk("reset regs", 17'h0_0000, {1'b0, o_rd_data, o_rr_data});
        chk("reset page", 17'h0_0000, o_pm_addr);
        chk("reset valid", 17'h0_0001, {16'h0000, o_pm_valid});
        finish_test();
    end
endmodule : tb_top
bind cpu_working_register_file regfile_monitor #(.LARGE_MEM(LARGE_MEM)) i_regfile_monitor (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_rd_addr     (i_rd_addr),
    .i_res_we      (i_res_we),
    .i_res_addr    (i_res_addr),
    .i_res_data    (i_res_data),
    .i_ptr_sel     (i_ptr_sel),
    .i_ptr_we      (i_ptr_we),
    .i_ptr_data    (i_ptr_data),
    .i_ds_re       (i_ds_re),
    .i_ds_we       (i_ds_we),
    .i_ds_addr     (i_ds_addr),
    .i_pm_load     (i_pm_load),
    .i_ext_load    (i_ext_load),
    .o_rd_data     (o_rd_data),
    .o_ptr         (o_ptr),
    .o_pm_addr     (o_pm_addr),
    .o_pm_valid    (o_pm_valid),
    .o_ext_illegal (o_ext_illegal),
    .o_ds_rdata    (o_ds_rdata),
    .o_ds_hit      (o_ds_hit)
);
`default_nettype wire
